// >>> pm_access_pkg.sv
// Package with register map, field positions and timing for program memory access and IAP control.
package pm_access_pkg;
	localparam int ADDR_W = 14;
	localparam int WORD_W = 16;
	localparam int PAGE_WORDS = 32;
	localparam logic [13:0] RESET_VECTOR = 14'h0000;
	// Register byte offsets on APB
	localparam logic [7:0] OFS_TBL_PTR_LOW = 8'h00;
	localparam logic [7:0] OFS_TBL_PTR_HIGH = 8'h04;
	localparam logic [7:0] OFS_TBL_HIGH_LATCH = 8'h08;
	localparam logic [7:0] OFS_TBL_CMD = 8'h0c;
	localparam logic [7:0] OFS_TBL_RESULT = 8'h10;
	localparam logic [7:0] OFS_FLASH_CTRL = 8'h14;
	localparam logic [7:0] OFS_FLASH_CLR = 8'h18;
	localparam logic [7:0] OFS_FLASH_ADDR_LOW = 8'h1c;
	localparam logic [7:0] OFS_FLASH_ADDR_HIGH = 8'h20;
	localparam logic [7:0] OFS_FLASH_DATA_LOW = 8'h24;
	localparam logic [7:0] OFS_FLASH_DATA_HIGH = 8'h28;
	localparam logic [7:0] OFS_FETCH_ADDR = 8'h2c;
	// Control register bit positions
	localparam int BIT_EW_ENABLED = 7;
	localparam int BIT_EW_UNLOCK = 3;
	localparam int BIT_WRITE_START = 2;
	localparam int BIT_READ_ENABLE = 1;
	localparam int BIT_READ_START = 0;
	localparam int BIT_CLR_BUF = 0;
	// Table command bits: bit 0 start, bit 1 destination sector nonzero, bit 2 last page form
	localparam int BIT_TBL_START = 0;
	localparam int BIT_TBL_EXT = 1;
	localparam int BIT_TBL_LAST = 2;
	localparam logic [7:0] EW_UNLOCK_KEY = 8'ha5;
	localparam logic [4:0] LAST_WORD = 5'h1f;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Timing
	localparam int CLK_HZ = 25000000;
	localparam int INSTR_CYCLE_CLKS = 4;
	localparam int TABLE_INSTR_CYCLES = 2;
	localparam int TBL_CLKS = INSTR_CYCLE_CLKS * TABLE_INSTR_CYCLES;
	localparam int WRITE_TIME_US = 2000;
	localparam int WRITE_CLKS = (WRITE_TIME_US * (CLK_HZ / 1000000));
	localparam int READ_CLKS = 4;
endpackage

// >>> pm_access.sv
// Program memory table read and in-application flash programming controller with an APB slave.
// Functional notes
// - After reset the fetch address is the reset vector 0000H.
// - Table address is high table pointer concatenated above low table pointer.
// - Table read: low byte to destination result, high byte to table-high latch.
// - Sector 0 destination uses normal forms, other sectors extended forms.
// - Every table instruction takes two instruction cycles.
// - Table-high latch is software readable and writable.
// - Erase and write act on a whole page, reads on one word.
// - Page size and write buffer depth are 32 sixteen-bit words.
// - Erase/write enabled status rises only after the enable procedure completes.
// - Write buffer accepts data only while erase/write enabled is high.
// - Write start bit reads high while writing, hardware clears it when done.
// - Reads need read enable; read start shows busy, hardware clears it.
// - Page from high address and low bits 7:5; word from low bits 4:0.
// - Program memory holds 16K words of 16 bits.
// - Writing high data byte loads the word into buffer and increments address.
// - At word offset 11111b the address stops incrementing.
// - Clear-buffer bit clears buffer and self-clears; buffer clears after write.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module pm_access #(
	parameter int WRITE_CLKS = pm_access_pkg::WRITE_CLKS
) (
	input wire logic clk_in, // System clock
	input wire logic reset_n_in, // Async reset, active low
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB direction
	input wire logic [7:0] paddr_in, // APB byte address
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error on unmapped address
	output logic [13:0] fetch_addr_out // Instruction fetch address
);
	localparam int AW = pm_access_pkg::ADDR_W;
	localparam int DW = pm_access_pkg::WORD_W;
	localparam int PW = pm_access_pkg::PAGE_WORDS;

	typedef enum logic [1:0] {IDLE, READING, WRITING} flash_state_type;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [DW-1:0] prog_mem [0:(1<<AW)-1];
	logic [DW-1:0] wbuf_q [0:PW-1];
	logic [PW-1:0] wbuf_valid_q;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic wr_en;
	logic rd_en;
	logic mapped;
	assign wr_en = psel_in && penable_in && pwrite_in;
	assign rd_en = psel_in && penable_in && !pwrite_in;
	assign pready_out = 1'b1;
	always_comb begin
		case (paddr_in)
			pm_access_pkg::OFS_TBL_PTR_LOW, pm_access_pkg::OFS_TBL_PTR_HIGH, pm_access_pkg::OFS_TBL_HIGH_LATCH,
			pm_access_pkg::OFS_TBL_CMD, pm_access_pkg::OFS_TBL_RESULT, pm_access_pkg::OFS_FLASH_CTRL,
			pm_access_pkg::OFS_FLASH_CLR, pm_access_pkg::OFS_FLASH_ADDR_LOW, pm_access_pkg::OFS_FLASH_ADDR_HIGH,
			pm_access_pkg::OFS_FLASH_DATA_LOW, pm_access_pkg::OFS_FLASH_DATA_HIGH,
			pm_access_pkg::OFS_FETCH_ADDR: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	assign pslverr_out = psel_in && penable_in && !mapped;
	function automatic logic wr_at(input logic [7:0] ofs);
		wr_at = wr_en && (paddr_in == ofs);
	endfunction

	// ----------------------------------------
	// Fetch address
	// ----------------------------------------
	logic [13:0] fetch_q;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fetch_q <= pm_access_pkg::RESET_VECTOR;
		end else if (wr_at(pm_access_pkg::OFS_FETCH_ADDR)) begin
			fetch_q <= pwdata_in[13:0];
		end
	end
	assign fetch_addr_out = fetch_q;

	// ----------------------------------------
	// Table read
	// ----------------------------------------
	logic [7:0] tbl_ptr_low_q;
	logic [5:0] tbl_ptr_high_q;
	logic [7:0] table_high_latch_q;
	logic [7:0] tbl_result_q;
	logic [1:0] tbl_form_q;
	logic [3:0] tbl_cnt_q;
	logic tbl_busy_q;
	logic [13:0] tbl_addr;
	logic tbl_done;
	assign tbl_addr = {tbl_ptr_high_q, tbl_ptr_low_q};
	assign tbl_done = tbl_busy_q && (tbl_cnt_q == 4'(pm_access_pkg::TBL_CLKS - 1));
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tbl_ptr_low_q <= pm_access_pkg::RESET_BYTE;
			tbl_ptr_high_q <= 6'h00;
		end else begin
			if (wr_at(pm_access_pkg::OFS_TBL_PTR_LOW)) begin
				tbl_ptr_low_q <= pwdata_in[7:0];
			end
			if (wr_at(pm_access_pkg::OFS_TBL_PTR_HIGH)) begin
				tbl_ptr_high_q <= pwdata_in[5:0];
			end
		end
	end
	// Busy lasts two instruction cycles; a new command while busy is dropped
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tbl_busy_q <= 1'b0;
			tbl_cnt_q <= 4'h0;
			tbl_form_q <= 2'b00;
		end else if (tbl_busy_q) begin
			tbl_cnt_q <= tbl_cnt_q + 4'h1;
			if (tbl_done) begin
				tbl_busy_q <= 1'b0;
			end
		end else if (wr_at(pm_access_pkg::OFS_TBL_CMD) && pwdata_in[pm_access_pkg::BIT_TBL_START]) begin
			tbl_busy_q <= 1'b1;
			tbl_cnt_q <= 4'h0;
			// Extended form chosen when destination is outside sector 0
			tbl_form_q <= {pwdata_in[pm_access_pkg::BIT_TBL_LAST], pwdata_in[pm_access_pkg::BIT_TBL_EXT]};
		end
	end
	logic [13:0] tbl_eff_addr;
	// Last page form keeps only the low pointer byte within the top page
	assign tbl_eff_addr = tbl_form_q[1] ? {6'h3f, tbl_ptr_low_q} : tbl_addr;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			table_high_latch_q <= pm_access_pkg::RESET_BYTE;
			tbl_result_q <= pm_access_pkg::RESET_BYTE;
		end else if (tbl_done) begin
			tbl_result_q <= prog_mem[tbl_eff_addr][7:0];
			table_high_latch_q <= prog_mem[tbl_eff_addr][15:8];
		end else if (wr_at(pm_access_pkg::OFS_TBL_HIGH_LATCH)) begin
			table_high_latch_q <= pwdata_in[7:0];
		end
	end

	// ----------------------------------------
	// Flash control
	// ----------------------------------------
	logic [7:0] flash_address_low_q;
	logic [5:0] flash_address_high_q;
	logic [7:0] flash_data_low_byte_q;
	logic [7:0] flash_data_high_byte_q;
	logic erase_write_enabled_status_q;
	logic read_enable_q;
	logic clear_write_buffer_q;
	flash_state_type state_q;
	logic [31:0] op_cnt_q;
	logic [8:0] page_sel;
	logic [4:0] word_sel;
	logic ctrl_wr;
	logic start_wr;
	logic start_rd;
	logic op_done;
	logic data_high_wr;
	assign page_sel = {flash_address_high_q, flash_address_low_q[7:5]};
	assign word_sel = flash_address_low_q[4:0];
	assign ctrl_wr = wr_at(pm_access_pkg::OFS_FLASH_CTRL);
	assign start_wr = ctrl_wr && pwdata_in[pm_access_pkg::BIT_WRITE_START] && erase_write_enabled_status_q
		&& (state_q == IDLE);
	assign start_rd = ctrl_wr && pwdata_in[pm_access_pkg::BIT_READ_START] && !start_wr
		&& (pwdata_in[pm_access_pkg::BIT_READ_ENABLE] || read_enable_q) && (state_q == IDLE);
	assign data_high_wr = wr_at(pm_access_pkg::OFS_FLASH_DATA_HIGH);
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			erase_write_enabled_status_q <= 1'b0;
			read_enable_q <= 1'b0;
		end else if (ctrl_wr) begin
			read_enable_q <= pwdata_in[pm_access_pkg::BIT_READ_ENABLE];
			// Enable completes only with the unlock bit and key byte together
			if (pwdata_in[pm_access_pkg::BIT_EW_UNLOCK] && pwdata_in[15:8] == pm_access_pkg::EW_UNLOCK_KEY) begin
				erase_write_enabled_status_q <= 1'b1;
			end else if (!pwdata_in[pm_access_pkg::BIT_EW_UNLOCK]) begin
				erase_write_enabled_status_q <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_q <= IDLE;
			op_cnt_q <= 32'h0;
		end else begin
			case (state_q)
				IDLE: begin
					op_cnt_q <= 32'h0;
					if (start_wr) begin
						state_q <= WRITING;
					end else if (start_rd) begin
						state_q <= READING;
					end
				end
				READING, WRITING: begin
					op_cnt_q <= op_cnt_q + 32'h1;
					if (op_done) begin
						state_q <= IDLE;
					end
				end
				default: state_q <= IDLE;
			endcase
		end
	end
	assign op_done = (state_q == WRITING && op_cnt_q == 32'(WRITE_CLKS - 1))
		|| (state_q == READING && op_cnt_q == 32'(pm_access_pkg::READ_CLKS - 1));
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flash_address_low_q <= pm_access_pkg::RESET_BYTE;
			flash_address_high_q <= 6'h00;
		end else if (wr_at(pm_access_pkg::OFS_FLASH_ADDR_LOW)) begin
			flash_address_low_q <= pwdata_in[7:0];
		end else if (wr_at(pm_access_pkg::OFS_FLASH_ADDR_HIGH)) begin
			flash_address_high_q <= pwdata_in[5:0];
		end else if (data_high_wr && erase_write_enabled_status_q && state_q == IDLE
			&& word_sel != pm_access_pkg::LAST_WORD) begin
			flash_address_low_q <= flash_address_low_q + 8'h01;
		end
	end
	logic [7:0] rd_low_d;
	logic [7:0] rd_high_d;
	assign rd_low_d = prog_mem[{page_sel, word_sel}][7:0];
	assign rd_high_d = prog_mem[{page_sel, word_sel}][15:8];
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			flash_data_low_byte_q <= pm_access_pkg::RESET_BYTE;
			flash_data_high_byte_q <= pm_access_pkg::RESET_BYTE;
		end else if (state_q == READING && op_done) begin
			flash_data_low_byte_q <= rd_low_d;
			flash_data_high_byte_q <= rd_high_d;
		end else begin
			if (wr_at(pm_access_pkg::OFS_FLASH_DATA_LOW)) begin
				flash_data_low_byte_q <= pwdata_in[7:0];
			end
			if (data_high_wr) begin
				flash_data_high_byte_q <= pwdata_in[7:0];
			end
		end
	end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clear_write_buffer_q <= 1'b0;
		end else if (clear_write_buffer_q) begin
			clear_write_buffer_q <= 1'b0;
		end else if (wr_at(pm_access_pkg::OFS_FLASH_CLR) && pwdata_in[pm_access_pkg::BIT_CLR_BUF]) begin
			clear_write_buffer_q <= 1'b1;
		end
	end
	// Buffer clears on request or after a write; a word load in the same cycle still wins
	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++) begin : g_wbuf
			always_ff @(posedge clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					wbuf_q[gi] <= 16'h0000;
					wbuf_valid_q[gi] <= 1'b0;
				end else if (data_high_wr && erase_write_enabled_status_q && state_q == IDLE
					&& word_sel == 5'(gi)) begin
					wbuf_q[gi] <= {pwdata_in[7:0], flash_data_low_byte_q};
					wbuf_valid_q[gi] <= 1'b1;
				end else if (clear_write_buffer_q || (state_q == WRITING && op_done)) begin
					wbuf_q[gi] <= 16'h0000;
					wbuf_valid_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate
	// Whole page is programmed at write end; erased words read as zero
	always_ff @(posedge clk_in) begin
		if (state_q == WRITING && op_done) begin
			for (int i = 0; i < PW; i++) begin
				prog_mem[{page_sel, 5'(i)}] <= wbuf_valid_q[i] ? wbuf_q[i] : 16'h0000;
			end
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	logic [7:0] ctrl_rd;
	assign ctrl_rd = {erase_write_enabled_status_q, 4'h0, (state_q == WRITING), read_enable_q,
		(state_q == READING)};
	always_comb begin
		prdata_out = 32'h0;
		if (rd_en) begin
			case (paddr_in)
				pm_access_pkg::OFS_TBL_PTR_LOW: prdata_out = {24'h0, tbl_ptr_low_q};
				pm_access_pkg::OFS_TBL_PTR_HIGH: prdata_out = {26'h0, tbl_ptr_high_q};
				pm_access_pkg::OFS_TBL_HIGH_LATCH: prdata_out = {24'h0, table_high_latch_q};
				pm_access_pkg::OFS_TBL_CMD: prdata_out = {29'h0, tbl_form_q, tbl_busy_q};
				pm_access_pkg::OFS_TBL_RESULT: prdata_out = {24'h0, tbl_result_q};
				pm_access_pkg::OFS_FLASH_CTRL: prdata_out = {24'h0, ctrl_rd};
				pm_access_pkg::OFS_FLASH_CLR: prdata_out = {31'h0, clear_write_buffer_q};
				pm_access_pkg::OFS_FLASH_ADDR_LOW: prdata_out = {24'h0, flash_address_low_q};
				pm_access_pkg::OFS_FLASH_ADDR_HIGH: prdata_out = {26'h0, flash_address_high_q};
				pm_access_pkg::OFS_FLASH_DATA_LOW: prdata_out = {24'h0, flash_data_low_byte_q};
				pm_access_pkg::OFS_FLASH_DATA_HIGH: prdata_out = {24'h0, flash_data_high_byte_q};
				pm_access_pkg::OFS_FETCH_ADDR: prdata_out = {18'h0, fetch_q};
				default: prdata_out = 32'h0;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> pm_access_assertions.sv
// Port checker for the program memory access block.
`timescale 1ns/10ps
`default_nettype none
module pm_access_assertions #(
	parameter int WRITE_CLKS = pm_access_pkg::WRITE_CLKS
) (
	input wire logic clk_in, // Clock
	input wire logic reset_n_in, // Reset
	input wire logic psel_in, // Select
	input wire logic penable_in, // Enable
	input wire logic pwrite_in, // Write
	input wire logic [7:0] paddr_in, // Address
	input wire logic [31:0] pwdata_in, // Wdata
	input wire logic [31:0] prdata_out, // Rdata
	input wire logic pready_out, // Ready
	input wire logic pslverr_out, // Error
	input wire logic [13:0] fetch_addr_out // Fetch
);
	// ----------------
	// Reference timers
	// ----------------
	logic acc, rd, wr_c, wr_a, ew_q, rden_q, kind_q;
	logic [3:0] tbl_q;
	logic [15:0] fl_q;
	assign acc = psel_in && penable_in && pready_out;
	assign rd = acc && !pwrite_in;
	assign wr_a = acc && pwrite_in;
	assign wr_c = acc && pwrite_in && paddr_in == pm_access_pkg::OFS_FLASH_CTRL;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tbl_q <= 4'h0;
		end else if (acc && pwrite_in && paddr_in == pm_access_pkg::OFS_TBL_CMD && pwdata_in[0] && tbl_q == 4'h0) begin
			tbl_q <= 4'(pm_access_pkg::TBL_CLKS);
		end else if (tbl_q != 4'h0) begin
			tbl_q <= tbl_q - 4'h1;
		end
	end
	// A start is honoured only when idle, and a write start wins over a read start
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fl_q <= 16'h0;
			kind_q <= 1'b0;
		end else if (wr_c && fl_q == 16'h0 && pwdata_in[2] && ew_q) begin
			fl_q <= 16'(WRITE_CLKS);
			kind_q <= 1'b1;
		end else if (wr_c && fl_q == 16'h0 && pwdata_in[0] && (pwdata_in[1] || rden_q)) begin
			fl_q <= 16'(pm_access_pkg::READ_CLKS);
			kind_q <= 1'b0;
		end else if (fl_q != 16'h0) begin
			fl_q <= fl_q - 16'h1;
		end
	end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ew_q <= 1'b0;
			rden_q <= 1'b0;
		end else if (wr_c) begin
			rden_q <= pwdata_in[1];
			if (!pwdata_in[3] || pwdata_in[15:8] == pm_access_pkg::EW_UNLOCK_KEY) begin
				ew_q <= pwdata_in[3];
			end
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	a_fetch_reset: assert property ($rose(reset_n_in) |-> fetch_addr_out == pm_access_pkg::RESET_VECTOR)
		else $error("fetch address not at reset vector");
	a_table_busy: assert property (rd && paddr_in == pm_access_pkg::OFS_TBL_CMD |-> prdata_out[0] == (tbl_q != 4'h0))
		else $error("table busy time wrong");
	a_write_busy: assert property (rd && paddr_in == pm_access_pkg::OFS_FLASH_CTRL |-> prdata_out[2] == (kind_q && fl_q != 16'h0))
		else $error("write busy wrong");
	a_read_busy: assert property (rd && paddr_in == pm_access_pkg::OFS_FLASH_CTRL |-> prdata_out[0] == (!kind_q && fl_q != 16'h0))
		else $error("read busy wrong");
	a_ew_status: assert property (rd && paddr_in == pm_access_pkg::OFS_FLASH_CTRL |-> prdata_out[7] == ew_q)
		else $error("enable status wrong");
	a_no_overlap: assert property (rd && paddr_in == pm_access_pkg::OFS_FLASH_CTRL |-> !(prdata_out[2] && prdata_out[0]))
		else $error("read and write busy together");
	a_clear_self: assert property (rd && paddr_in == pm_access_pkg::OFS_FLASH_CLR |-> !prdata_out[0])
		else $error("clear bit stuck");
	a_latch_rw: assert property (rd && paddr_in == pm_access_pkg::OFS_TBL_HIGH_LATCH && $past(wr_a, 3)
		&& $past(paddr_in, 3) == paddr_in && tbl_q == 4'h0 && $past(tbl_q, 3) == 4'h0
		|-> prdata_out[7:0] == $past(pwdata_in[7:0], 3))
		else $error("latch readback wrong");
endmodule
bind pm_access pm_access_assertions #(.WRITE_CLKS(WRITE_CLKS)) pm_access_assertions_inst (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.fetch_addr_out(fetch_addr_out));
`default_nettype wire

// >>> fw_master.sv
// Firmware-side bus master model issuing single register accesses.
`timescale 1ns/10ps
`default_nettype none
module fw_master (
	input wire logic clk_in, // Clock
	input wire logic pready_in, // Ready
	input wire logic pslverr_in, // Error
	input wire logic [31:0] prdata_in, // Rdata
	output logic psel_out, // Select
	output logic penable_out, // Enable
	output logic pwrite_out, // Write
	output logic [7:0] paddr_out, // Address
	output logic [31:0] pwdata_out // Wdata
);
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'hff;
		pwdata_out = 32'h0;
	end
	// Accesses go one at a time, so table reads never overlap
	// A page program carries its own erase, so none is issued apart
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		logic r;
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		penable_out <= 1'b1;
		// Answer is taken at the same rising edge that sees pready high, never earlier
		do begin
			@(posedge clk_in);
			r = pready_in;
			q = prdata_in;
			e = pslverr_in;
		end while (r !== 1'b1);
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		paddr_out <= ~a;
		pwdata_out <= ~d;
	endtask
endmodule
`default_nettype wire

// >>> pm_access_tb_top.sv
// Testbench for the program memory access block.
`timescale 1ns/10ps
`default_nettype none
module pm_access_tb_top;
	localparam logic [7:0] CTL = pm_access_pkg::OFS_FLASH_CTRL;
	localparam logic [7:0] AL = pm_access_pkg::OFS_FLASH_ADDR_LOW;
	localparam logic [7:0] DL = pm_access_pkg::OFS_FLASH_DATA_LOW;
	localparam logic [7:0] DH = pm_access_pkg::OFS_FLASH_DATA_HIGH;
	logic clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [13:0] fetch_addr;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	pm_access #(.WRITE_CLKS(20)) pm_access_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .fetch_addr_out(fetch_addr));
	fw_master fw_master_inst (.clk_in(clk_in), .pready_in(pready), .pslverr_in(pslverr), .prdata_in(prdata),
		.psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		fw_master_inst.xfer(1'b1, a, d, q, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		fw_master_inst.xfer(1'b0, a, 32'h0, q, e);
		chk(q & m, exp);
	endtask
	task automatic wait_idle(input logic [7:0] a, input logic [31:0] m);
		logic [31:0] q;
		logic e;
		q = m;
		for (int i = 0; i < 50 && (q & m) != 32'h0; i++) begin
			fw_master_inst.xfer(1'b0, a, 32'h0, q, e);
		end
		chk(q & m, 32'h0);
	endtask
	// ---------
	// Scenarios
	// ---------
	task automatic t_reset_map();
		logic [31:0] q;
		logic e;
		chk({18'h0, fetch_addr}, 32'h0);
		rd_chk(pm_access_pkg::OFS_FETCH_ADDR, 32'h3fff, 32'h0);
		fw_master_inst.xfer(1'b0, 8'h30, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
	endtask
	task automatic t_fill();
		wr(CTL, 32'ha508);
		rd_chk(CTL, 32'h80, 32'h80);
		wr(pm_access_pkg::OFS_FLASH_ADDR_HIGH, 32'h3f);
		wr(AL, 32'he0);
		wr(DL, 32'h11);
		wr(DH, 32'h22);
		rd_chk(AL, 32'hff, 32'he1);
		wr(pm_access_pkg::OFS_FLASH_CLR, 32'h1);
		rd_chk(pm_access_pkg::OFS_FLASH_CLR, 32'h1, 32'h0);
		wr(AL, 32'hfe);
		wr(DL, 32'h2b);
		wr(DH, 32'h1a);
		wr(DL, 32'h99);
		wr(DH, 32'h88);
		rd_chk(AL, 32'hff, 32'hff);
		wr(CTL, 32'h0);
		rd_chk(CTL, 32'h80, 32'h0);
		wr(AL, 32'he1);
		wr(DH, 32'h77);
		rd_chk(AL, 32'hff, 32'he1);
	endtask
	task automatic t_program();
		wr(CTL, 32'ha508);
		wr(AL, 32'he0);
		wr(CTL, 32'ha50c);
		rd_chk(CTL, 32'h4, 32'h4);
		wr(CTL, 32'ha50b);
		rd_chk(CTL, 32'h5, 32'h4);
		wait_idle(CTL, 32'h4);
		wr(AL, 32'hfe);
		wr(CTL, 32'ha50b);
		rd_chk(CTL, 32'h1, 32'h1);
		wait_idle(CTL, 32'h1);
		rd_chk(DL, 32'hff, 32'h2b);
		rd_chk(DH, 32'hff, 32'h1a);
	endtask
	task automatic tbl(input logic [31:0] c, input logic [31:0] pt, input logic [31:0] w);
		wr(pm_access_pkg::OFS_TBL_PTR_HIGH, {24'h0, pt[15:8]});
		wr(pm_access_pkg::OFS_TBL_PTR_LOW, {24'h0, pt[7:0]});
		wr(pm_access_pkg::OFS_TBL_CMD, c);
		rd_chk(pm_access_pkg::OFS_TBL_CMD, 32'h1, 32'h1);
		wait_idle(pm_access_pkg::OFS_TBL_CMD, 32'h1);
		rd_chk(pm_access_pkg::OFS_TBL_CMD, 32'h6, c & 32'h6);
		rd_chk(pm_access_pkg::OFS_TBL_RESULT, 32'hff, {24'h0, w[7:0]});
		rd_chk(pm_access_pkg::OFS_TBL_HIGH_LATCH, 32'hff, {24'h0, w[15:8]});
	endtask
	task automatic t_table();
		tbl(32'h1, 32'h3fff, 32'h8899);
		tbl(32'h3, 32'h3ffe, 32'h1a2b);
		tbl(32'h5, 32'h00e1, 32'h0);
		tbl(32'h7, 32'h00e0, 32'h0);
		wr(pm_access_pkg::OFS_TBL_HIGH_LATCH, 32'h5a);
		rd_chk(pm_access_pkg::OFS_TBL_HIGH_LATCH, 32'hff, 32'h5a);
	endtask
	initial begin
		reset_n_in = 1'b0;
		repeat (10) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_reset_map();
		t_fill();
		t_program();
		t_table();
		summarize();
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end
endmodule
`default_nettype wire
